// ===== dv/bus_host_model.sv
// Bus host model that issues single-byte register reads and writes.
// Assumes the register block samples strobes on the rising core_clk edge.
`timescale 1ns/1ps
module bus_host_model (
  // Clock and returned data
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  // Request lines
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            reg_remote,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // Idle state at time zero.
  initial begin
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_remote = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
  end

  // ****************************************
  // One access
  // ****************************************
  // Address and data are inverted once released, so stale values are never trusted.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_remote <= (a == 8'h02);
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(posedge core_clk);
    #1 q = reg_rdata;
  endtask
endmodule

// ===== dv/serializer_config_registers_tb.sv
// Self-checking bench for the serializer configuration register group.
// Assumes the bus host model drives all register traffic.
`timescale 1ns/1ps
module serializer_config_registers_tb;
  logic        core_clk, srst, powerdown_n_pin, address_strap_pin;
  logic [6:0]  strap_bus_address, own_bus_address;
  logic [2:0]  strap_op_mode, op_mode;
  logic        reg_wr, reg_rd, reg_remote;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, q, v;
  logic        rom_reload_trigger, logic_reset, clock_lane_continuous, crc_tx_enable, bus_level_1v8;
  logic [1:0]  lane_count_sel;
  logic        sync_mode, nsync_ext_mode, nsync_aon_mode, parallel_video_port_mode, local_clock_required;
  logic [31:0] seed;
  logic [6:0]  prog_addr;
  int          errors, num_checks, reloads, lresets;
  logic [2:0]  codes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
  logic [1:0]  lanes [3] = '{2'h0, 2'h1, 2'h3};

  serializer_config_registers dut (
    .core_clk(core_clk), .srst(srst), .powerdown_n_pin(powerdown_n_pin),
    .strap_bus_address(strap_bus_address), .address_strap_pin(address_strap_pin),
    .strap_op_mode(strap_op_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_remote(reg_remote),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .own_bus_address(own_bus_address), .rom_reload_trigger(rom_reload_trigger),
    .logic_reset(logic_reset), .clock_lane_continuous(clock_lane_continuous),
    .lane_count_sel(lane_count_sel), .crc_tx_enable(crc_tx_enable), .bus_level_1v8(bus_level_1v8),
    .op_mode(op_mode), .sync_mode(sync_mode), .nsync_ext_mode(nsync_ext_mode),
    .nsync_aon_mode(nsync_aon_mode), .parallel_video_port_mode(parallel_video_port_mode),
    .local_clock_required(local_clock_required));

  bus_host_model host (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_remote(reg_remote), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ****************************************
  // Clock, pulse counters and helpers
  // ****************************************
  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Trigger pulses are counted, since a pulse that sticks would count many times.
  always @(posedge core_clk) begin
    if (rom_reload_trigger === 1'b1) reloads++;
    if (logic_reset === 1'b1) lresets++;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] mode_exp(logic ovr, logic done, logic [2:0] m);
    return {1'b0, strap_op_mode[2], 1'b0, ovr, done, m};
  endfunction

  function automatic logic [7:0] dec_exp(logic [2:0] m);
    return {3'h0, m == 3'h0, m == 3'h2, m == 3'h3, m == 3'h5, (m == 3'h2) || (m == 3'h5)};
  endfunction

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    host.access(1'b0, a, 8'h00, q);
    chk8(n, e, q & m);
  endtask

  // Pin low clears the done flag; the new strap is latched after the settle time.
  task automatic relatch(input logic [2:0] m);
    @(posedge core_clk);
    powerdown_n_pin <= 1'b0;
    strap_op_mode   <= m;
    rd_chk("done_low", 8'h03, 8'h00, 8'h08);
    @(posedge core_clk);
    powerdown_n_pin <= 1'b1;
    repeat (12) @(posedge core_clk);
    rd_chk("mode_latched", 8'h03, mode_exp(1'b0, 1'b1, m));
    chk8("decodes", dec_exp(m), {3'h0, sync_mode, nsync_ext_mode, nsync_aon_mode, parallel_video_port_mode, local_clock_required});
    chk8("op_mode", {5'h00, m}, {5'h00, op_mode});
  endtask

  task automatic summarize();
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'h00010c4d;
    srst = 1'b1;
    powerdown_n_pin = 1'b0;
    address_strap_pin = 1'b1;
    strap_op_mode = 3'h3;
    v = rnd();
    strap_bus_address = v[7:1];
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    relatch(3'h3);
    rd_chk("addr_reset", 8'h00, {strap_bus_address, 1'b0});
    rd_chk("rst_ctl", 8'h01, 8'h00);
    wr(8'hf8 == 8'hf8 ? 8'h01 : 8'h01, 8'hf8);
    rd_chk("rst_rsvd", 8'h01, 8'hf8);
    rd_chk("gencfg_reset", 8'h02, {7'h19, address_strap_pin});
    v = rnd();
    prog_addr = v[7:1];
    wr(8'h00, {v[7:1], 1'b0});
    rd_chk("addr_locked", 8'h00, {strap_bus_address, 1'b0});
    wr(8'h00, 8'h01);
    wr(8'h00, {v[7:1], 1'b1});
    rd_chk("addr_override", 8'h00, {v[7:1], 1'b1});
    chk8("addr_port", {1'b0, v[7:1]}, {1'b0, own_bus_address});
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      v[5:4] = lanes[i % 3];
      wr(8'h02, v);
      rd_chk("gencfg_rw", 8'h02, v);
      chk8("cfg_ports", {3'h0, v[6], v[5:4], v[1], v[0]}, {3'h0, clock_lane_continuous, lane_count_sel, crc_tx_enable, bus_level_1v8});
    end
    wr(8'h03, 8'h05);
    rd_chk("mode_locked", 8'h03, mode_exp(1'b0, 1'b1, 3'h3));
    wr(8'h03, 8'h10);
    foreach (codes[i]) begin
      wr(8'h03, {5'h02, codes[i]});
      rd_chk("mode_ovr", 8'h03, mode_exp(1'b1, 1'b1, codes[i]));
      chk8("mode_dec", dec_exp(codes[i]), {3'h0, sync_mode, nsync_ext_mode, nsync_aon_mode, parallel_video_port_mode, local_clock_required});
      chk8("op_mode_ovr", {5'h00, codes[i]}, {5'h00, op_mode});
    end
    wr(8'h03, 8'hb0);
    rd_chk("mode_rsvd", 8'h03, 8'hb8, 8'hb8);
    wr(8'h03, 8'h00);
    relatch(3'h5);
    wr(8'h07, rnd());
    rd_chk("unmapped", 8'h07, 8'h00);
    wr(8'h02, 8'hc1);
    wr(8'h01, 8'h04);
    rd_chk("selfclear", 8'h01, 8'h00);
    chk8("reloads", 8'h01, reloads[7:0]);
    wr(8'h01, 8'h01);
    rd_chk("keep_regs", 8'h02, 8'hc1);
    rd_chk("keep_addr", 8'h00, {prog_addr, 1'b1});
    wr(8'h01, 8'h02);
    rd_chk("full_clear", 8'h02, 8'h32, 8'hfe);
    rd_chk("addr_cleared", 8'h00, {strap_bus_address, 1'b0});
    chk8("lresets", 8'h02, lresets[7:0]);
    summarize();
  end
endmodule

// ===== rtl/ser_cfg_pkg.sv
// Constants for the serializer configuration register group.
// Assumes an upstream serial-bus slave that presents byte-wide register accesses.
package ser_cfg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_BUS_ADDRESS_SELECT    = 8'h00;
  localparam logic [7:0] ADDR_RESET_CONTROL         = 8'h01;
  localparam logic [7:0] ADDR_GENERAL_CONFIG        = 8'h02;
  localparam logic [7:0] ADDR_OPERATING_MODE_SELECT = 8'h03;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_ADDR_OVERRIDE = 0;
  localparam int BIT_ROM_RELOAD    = 2;
  localparam int BIT_FULL_RESET    = 1;
  localparam int BIT_LOGIC_RESET   = 0;
  localparam int BIT_CLK_CONT      = 6;
  localparam int BIT_LANE_LO       = 4;
  localparam int BIT_CRC_EN        = 1;
  localparam int BIT_BUS_LEVEL     = 0;
  localparam int BIT_MODE_OVERRIDE = 4;
  localparam int BIT_MODE_DONE     = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_RESET_CONTROL = 8'h00;
  localparam logic [7:0] RST_GENCFG_FIXED  = 8'h32;  // Four lanes, CRC on, level from strap.
  localparam logic [7:0] RST_MODE_RSVD     = 8'h00;
  localparam logic [1:0] LANES_ONE         = 2'h0;
  localparam logic [1:0] LANES_TWO         = 2'h1;
  localparam logic [1:0] LANES_FOUR        = 2'h3;

  // Cycles that the power-down pin must stay high before the strapped mode is latched.
  localparam logic [3:0] MODE_SETTLE_CYCLES = 4'h8;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [2:0] {
    MODE_SYNC      = 3'h0,
    MODE_RSVD1     = 3'h1,
    MODE_NSYNC_EXT = 3'h2,
    MODE_NSYNC_AON = 3'h3,
    MODE_RSVD4     = 3'h4,
    MODE_PVP_EXT   = 3'h5,
    MODE_RSVD6     = 3'h6,
    MODE_RSVD7     = 3'h7
  } op_mode_t;

endpackage

// ===== rtl/serializer_config_registers.sv
// Register group for own bus address, soft resets, camera interface setup and mode select.
// Assumes a serial-bus slave upstream delivers one-cycle byte read and write strobes,
// with a flag that marks writes arriving remotely over the back channel.
`timescale 1ns/1ps

// Behaviour
// - Address register bits 7:1 always read the active own bus address.
// - Address field ignores writes unless override set; then accepts any address.
// - Address bit 0 selects strapped address or register-programmed address.
// - Writing 1 to reset bit 2 pulses ROM reload, then clears.
// - Writing 1 to reset bit 1 resets logic and registers but keeps the latched strap mode and done flag, self-clears.
// - Writing 1 to reset bit 0 resets logic but keeps registers, self-clears.
// - Config bit 6 selects gated or continuous clock lane, reset 0.
// - Config bits 5:4 select one, two or four lanes, reset four.
// - Config bit 0 loads bus level from strap at start-up, then writable.
// - Mode bit 4 selects strapped mode or register mode.
// - Mode bit 3 reads 1 once mode has settled and latched.
// - Mode bits 2:0 show active mode; writable only under override.
// - Mode is captured from strap eight cycles after the power-down pin rises.
// - Codes 000 sync, 010 external-clock, 011 always-on clock; 001 reserved.
// - Code 101 selects parallel video port mode needing a local clock.
// - Self-clearing fields take a written 1 and return to 0 alone.
// - Strapped fields take start-up values from pins sampled at start-up; the address here follows its strap pins live.
module serializer_config_registers (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Straps and power-down pin
  input  wire logic       powerdown_n_pin,
  input  wire logic [6:0] strap_bus_address,
  input  wire logic       address_strap_pin,
  input  wire logic [2:0] strap_op_mode,
  // Register access from the serial-bus slave
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       reg_remote,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Configuration outputs
  output logic      [6:0] own_bus_address,
  output logic            rom_reload_trigger,
  output logic            logic_reset,
  output logic            clock_lane_continuous,
  output logic      [1:0] lane_count_sel,
  output logic            crc_tx_enable,
  output logic            bus_level_1v8,
  output logic      [2:0] op_mode,
  output logic            sync_mode,
  output logic            nsync_ext_mode,
  output logic            nsync_aon_mode,
  output logic            parallel_video_port_mode,
  output logic            local_clock_required
);

  // ****************************************
  // Decode
  // ****************************************

  // Address match helper, used for every register strobe.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [6:0] addr_prog_r;
  logic       address_override_r;
  logic [4:0] rstctl_rsvd_r;
  logic       rom_reload_r;
  logic       full_reset_r;
  logic       logic_reset_r;
  logic [7:0] gencfg_r;
  logic [2:0] mode_prog_r;
  logic       op_mode_override_r;
  logic [1:0] mode_rsvd_r;
  logic       mode_done_r;
  logic [2:0] mode_latched_r;
  logic       pdn_d_r;
  logic [3:0] settle_cnt_r;
  logic       boot_r;
  logic [6:0] own_bus_address_r;
  logic [2:0] op_mode_r;
  logic [7:0] reg_rdata_r;
  logic       sync_mode_r;
  logic       nsync_ext_mode_r;
  logic       nsync_aon_mode_r;
  logic       pvp_mode_r;
  logic       local_clock_r;

  wire        wr_addr  = reg_wr & hit(reg_addr, ser_cfg_pkg::ADDR_BUS_ADDRESS_SELECT);
  wire        wr_rst   = reg_wr & hit(reg_addr, ser_cfg_pkg::ADDR_RESET_CONTROL);
  wire        wr_cfg   = reg_wr & hit(reg_addr, ser_cfg_pkg::ADDR_GENERAL_CONFIG);
  wire        wr_mode  = reg_wr & hit(reg_addr, ser_cfg_pkg::ADDR_OPERATING_MODE_SELECT);
  // full reset, folded into the register reset.
  wire        reg_clr  = srst | full_reset_r;
  // Power-down pin rising edge starts mode capture.
  wire        pdn_rise = powerdown_n_pin & ~pdn_d_r;

  wire [6:0] addr_active = address_override_r ? addr_prog_r : strap_bus_address;
  wire [2:0] mode_active = op_mode_override_r ? mode_prog_r : mode_latched_r;
  // mode decode, registered below so that every decode output leaves a flop.
  wire       dec_sync      = (mode_active == ser_cfg_pkg::MODE_SYNC);
  wire       dec_nsync_ext = (mode_active == ser_cfg_pkg::MODE_NSYNC_EXT);
  wire       dec_nsync_aon = (mode_active == ser_cfg_pkg::MODE_NSYNC_AON);
  wire       dec_pvp       = (mode_active == ser_cfg_pkg::MODE_PVP_EXT);

  wire [7:0] rd_addr = {addr_active, address_override_r};
  wire [7:0] rd_rst  = {rstctl_rsvd_r, 3'h0};
  wire [7:0] rd_mode = {mode_rsvd_r[1], strap_op_mode[2], mode_rsvd_r[0], op_mode_override_r,
                        mode_done_r, mode_active};
  wire [7:0] rd_mux  = hit(reg_addr, ser_cfg_pkg::ADDR_BUS_ADDRESS_SELECT)    ? rd_addr  :
                       hit(reg_addr, ser_cfg_pkg::ADDR_RESET_CONTROL)         ? rd_rst   :
                       hit(reg_addr, ser_cfg_pkg::ADDR_GENERAL_CONFIG)        ? gencfg_r :
                       hit(reg_addr, ser_cfg_pkg::ADDR_OPERATING_MODE_SELECT) ? rd_mode  : 8'h00;

  // ****************************************
  // Address register
  // ****************************************

  // address writable only under override; the override bit is always writable.
  always_ff @(posedge core_clk) begin
    if (reg_clr) begin
      address_override_r <= 1'b0;
      addr_prog_r        <= 7'h00;
    end else if (wr_addr) begin
      address_override_r <= reg_wdata[ser_cfg_pkg::BIT_ADDR_OVERRIDE];
      if (address_override_r) begin
        addr_prog_r <= reg_wdata[7:1];
      end else begin
        addr_prog_r <= strap_bus_address;  // Keeps the switch-over seamless.
      end
    end
  end

  // ****************************************
  // Reset control
  // ****************************************

  // self-clearing triggers: held one cycle, then back to zero.
  // reload pulse and logic-only reset pulse.
  always_ff @(posedge core_clk) begin
    if (reg_clr) begin
      rom_reload_r  <= 1'b0;
      logic_reset_r <= 1'b0;
      rstctl_rsvd_r <= ser_cfg_pkg::RST_RESET_CONTROL[7:3];
    end else begin
      rom_reload_r  <= wr_rst & reg_wdata[ser_cfg_pkg::BIT_ROM_RELOAD];
      // Either soft reset raises the datapath reset; after a full reset, reg_clr ends it after one cycle.
      logic_reset_r <= wr_rst & (reg_wdata[ser_cfg_pkg::BIT_LOGIC_RESET] | reg_wdata[ser_cfg_pkg::BIT_FULL_RESET]);
      if (wr_rst) begin
        rstctl_rsvd_r <= reg_wdata[7:3];
      end
    end
  end

  // Full reset trigger lives outside reg_clr so it clears itself after one cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      full_reset_r <= 1'b0;
    end else begin
      full_reset_r <= wr_rst & reg_wdata[ser_cfg_pkg::BIT_FULL_RESET] & ~full_reset_r;
    end
  end

  // ****************************************
  // General configuration
  // ****************************************

  // bus level is caught from the strap in the cycle after reset release.
  // the local/remote flag is not enforced; the far side is trusted.
  always_ff @(posedge core_clk) begin
    if (reg_clr) begin
      gencfg_r <= ser_cfg_pkg::RST_GENCFG_FIXED;
      boot_r   <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      if (boot_r) begin
        gencfg_r[ser_cfg_pkg::BIT_BUS_LEVEL] <= address_strap_pin;
      end else if (wr_cfg) begin
        gencfg_r <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Mode select
  // ****************************************

  // mode field writable only under override.
  always_ff @(posedge core_clk) begin
    if (reg_clr) begin
      op_mode_override_r <= 1'b0;
      mode_prog_r        <= 3'h0;
      mode_rsvd_r        <= ser_cfg_pkg::RST_MODE_RSVD[1:0];
    end else if (wr_mode) begin
      op_mode_override_r <= reg_wdata[ser_cfg_pkg::BIT_MODE_OVERRIDE];
      mode_rsvd_r        <= {reg_wdata[7], reg_wdata[5]};
      mode_prog_r        <= op_mode_override_r ? reg_wdata[2:0] : mode_active;
    end
  end

  // capture strap after power-down release and a settle time.
  // done flag rises when the capture completes.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pdn_d_r        <= 1'b0;
      settle_cnt_r   <= 4'h0;
      mode_done_r    <= 1'b0;
      mode_latched_r <= 3'h0;
    end else begin
      pdn_d_r <= powerdown_n_pin;
      if (!powerdown_n_pin || pdn_rise) begin
        settle_cnt_r <= 4'h0;
        mode_done_r  <= 1'b0;
      end else if (!mode_done_r) begin
        settle_cnt_r <= settle_cnt_r + 4'h1;
        if (settle_cnt_r == ser_cfg_pkg::MODE_SETTLE_CYCLES - 4'h1) begin
          mode_done_r    <= 1'b1;
          mode_latched_r <= strap_op_mode;
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // active address and read data registered for the bus.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      own_bus_address_r <= 7'h00;
      op_mode_r         <= 3'h0;
      reg_rdata_r       <= 8'h00;
      sync_mode_r       <= 1'b1;  // Mode code zero after reset is the synchronous mode.
      nsync_ext_mode_r  <= 1'b0;
      nsync_aon_mode_r  <= 1'b0;
      pvp_mode_r        <= 1'b0;
      local_clock_r     <= 1'b0;
    end else begin
      own_bus_address_r <= addr_active;
      op_mode_r         <= mode_active;
      sync_mode_r       <= dec_sync;
      nsync_ext_mode_r  <= dec_nsync_ext;
      nsync_aon_mode_r  <= dec_nsync_aon;
      pvp_mode_r        <= dec_pvp;
      local_clock_r     <= dec_nsync_ext | dec_pvp;
      if (reg_rd) begin
        reg_rdata_r <= rd_mux;
      end
    end
  end

  assign own_bus_address       = own_bus_address_r;
  assign reg_rdata             = reg_rdata_r;
  assign rom_reload_trigger    = rom_reload_r;
  // Both soft resets drive the datapath reset; a full reset also clears the registers.
  assign logic_reset           = logic_reset_r;
  assign clock_lane_continuous = gencfg_r[ser_cfg_pkg::BIT_CLK_CONT];
  assign lane_count_sel        = gencfg_r[ser_cfg_pkg::BIT_LANE_LO +: 2];
  assign crc_tx_enable         = gencfg_r[ser_cfg_pkg::BIT_CRC_EN];
  assign bus_level_1v8         = gencfg_r[ser_cfg_pkg::BIT_BUS_LEVEL];
  assign op_mode               = op_mode_r;

  // mode decodes, each from its own flop.
  assign sync_mode                = sync_mode_r;
  assign nsync_ext_mode           = nsync_ext_mode_r;
  assign nsync_aon_mode           = nsync_aon_mode_r;
  assign parallel_video_port_mode = pvp_mode_r;
  assign local_clock_required     = local_clock_r;

  // ****************************************
  // Checks
  // ****************************************

  // reload pulse follows the write and lasts one cycle.
  a_reload_pulse: assert property (@(posedge core_clk) disable iff (srst || full_reset_r)
    wr_rst && reg_wdata[2] |=> rom_reload_trigger ##1 !rom_reload_trigger)
    else $error("rom reload pulse wrong");

  // full reset clears override bits next cycle.
  a_full_reset: assert property (@(posedge core_clk) disable iff (srst)
    full_reset_r |=> !address_override_r && !op_mode_override_r && gencfg_r[1])
    else $error("full reset did not clear registers");

  a_logic_keep: assert property (@(posedge core_clk) disable iff (srst)
    wr_rst && reg_wdata == 8'h01 && !full_reset_r |=> logic_reset && $stable(gencfg_r))
    else $error("logic reset disturbed registers");

  a_addr_lock: assert property (@(posedge core_clk) disable iff (srst)
    !address_override_r && !reg_wr ##1 !address_override_r |-> own_bus_address == $past(strap_bus_address))
    else $error("address changed without override");

  // done rises eight cycles after release when pin holds high.
  sequence pdn_release_s;
    pdn_rise ##1 powerdown_n_pin [*8];
  endsequence
  a_mode_done: assert property (@(posedge core_clk) disable iff (srst)
    pdn_release_s |=> mode_done_r)
    else $error("mode done late");

  // latched mode equals the strap at completion.
  a_mode_latch: assert property (@(posedge core_clk) disable iff (srst)
    $rose(mode_done_r) |-> mode_latched_r == $past(strap_op_mode))
    else $error("mode not captured from strap");

  // bus level follows strap after boot.
  a_level_boot: assert property (@(posedge core_clk) disable iff (srst || full_reset_r)
    boot_r |=> bus_level_1v8 == $past(address_strap_pin))
    else $error("bus level not strapped");

  a_mode_over: assert property (@(posedge core_clk) disable iff (srst)
    op_mode_override_r && $stable(mode_prog_r) |=> op_mode == $past(mode_prog_r))
    else $error("override mode not active");

  // read-back address matches the address the device answers to.
  a_addr_readback: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == ser_cfg_pkg::ADDR_BUS_ADDRESS_SELECT |=> reg_rdata[7:1] == own_bus_address)
    else $error("address read-back differs from active address");

  // self-clearing trigger bits always read back as zero.
  a_rst_selfclr: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == ser_cfg_pkg::ADDR_RESET_CONTROL |=> reg_rdata[2:0] == 3'h0)
    else $error("self-clearing bit read back as one");

  // a new address written while the override was already set lands two cycles later.
  a_addr_prog: assert property (@(posedge core_clk) disable iff (srst || full_reset_r)
    wr_addr && address_override_r && reg_wdata[0] |=> ##1 own_bus_address == $past(reg_wdata[7:1], 2))
    else $error("programmed address not applied");

  // the bus level bit takes a later write like any other field.
  a_level_write: assert property (@(posedge core_clk) disable iff (srst || full_reset_r)
    wr_cfg && !boot_r |=> bus_level_1v8 == $past(reg_wdata[ser_cfg_pkg::BIT_BUS_LEVEL]))
    else $error("bus level write lost");

  // the active mode ignores a mode write made while the override was clear.
  a_mode_lock: assert property (@(posedge core_clk) disable iff (srst || full_reset_r)
    wr_mode && !op_mode_override_r && mode_done_r |=> $stable(mode_active))
    else $error("mode changed without override");

  // full reset restores gated clock lane, four lanes and CRC on.
  a_cfg_reset: assert property (@(posedge core_clk) disable iff (srst)
    full_reset_r |=> crc_tx_enable && lane_count_sel == ser_cfg_pkg::LANES_FOUR && !clock_lane_continuous)
    else $error("configuration reset values wrong");

  // the modes that need a local clock raise the local clock flag.
  a_mode_decode: assert property (@(posedge core_clk) disable iff (srst)
    local_clock_required == (op_mode == ser_cfg_pkg::MODE_NSYNC_EXT || op_mode == ser_cfg_pkg::MODE_PVP_EXT))
    else $error("local clock flag wrong for mode");

endmodule
